// *** logic/skip_and_table_read_exec.sv ***
// file: execution of the skip-if-zero and page table-read instructions
// assumes one instruction offered per cycle with data memory read data valid alongside
// How it works
// - skip-zero-load copies the data-memory byte into the accumulator
// - skip-zero-load skips the next instruction when the byte is zero
// - a taken skip inserts two dummy cycles, three cycles in all
// - a nonzero tested value continues normally with no dummy cycle
// - skip-bit tests the chosen bit and skips when that bit is zero
// - a taken skip-bit also costs three cycles through the two dummy cycles
// - table read forms page address from pointers, low byte to data memory
// - table read puts the word's high byte into the table-high latch
`default_nettype none
module skip_and_table_read_exec (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire skip_exec_pkg::op_e op_i,
    input wire logic [skip_exec_pkg::ADDR_W-1:0] mem_addr_i,
    input wire logic [skip_exec_pkg::BIT_SEL_W-1:0] bit_sel_i,
    input wire logic [skip_exec_pkg::DATA_W-1:0] mem_rdata_i,
    input wire logic [skip_exec_pkg::DATA_W-1:0] table_ptr_high_i,
    input wire logic [skip_exec_pkg::DATA_W-1:0] table_ptr_low_i,
    input wire logic [skip_exec_pkg::PWORD_W-1:0] prog_rdata_i,
    input wire logic prog_rvalid_i,
    input wire logic [skip_exec_pkg::DATA_W-1:0] flags_i,
    output logic busy_o,
    output logic exec_enable_o,
    output logic dummy_cycle_o,
    output logic [skip_exec_pkg::DATA_W-1:0] acc_o,
    output logic [skip_exec_pkg::DATA_W-1:0] table_high_latch_o,
    output logic [skip_exec_pkg::PADDR_W-1:0] prog_addr_o,
    output logic prog_req_o,
    output logic mem_we_o,
    output logic [skip_exec_pkg::ADDR_W-1:0] mem_waddr_o,
    output logic [skip_exec_pkg::DATA_W-1:0] mem_wdata_o,
    output logic [skip_exec_pkg::DATA_W-1:0] flags_o
);
    import skip_exec_pkg::*;

    typedef enum logic [1:0] {ST_EXEC, ST_SKIP_FETCH, ST_DUMMY, ST_TABLE} state_e;

    // both skip opcodes share the zero test and the discard slots
    function automatic logic is_skip_op(input op_e op);
        return (op == OP_SKIP_ZERO_LOAD_ACC) || (op == OP_SKIP_BIT_ZERO);
    endfunction

    // only the table read waits on program memory
    function automatic logic is_table_op(input op_e op);
        return op == OP_TABLE_READ_PAGE;
    endfunction

    // the word must carry both bytes and the two pointers must fill the address
    if (HIGH_BYTE_LSB + DATA_W > PWORD_W
        || LOW_BYTE_LSB + DATA_W > HIGH_BYTE_LSB) begin : g_word_chk
        $error("program word too narrow for the table read");
    end
    if (DATA_W + DATA_W != PADDR_W) begin : g_addr_chk
        $error("table pointers do not fill the program address");
    end

    state_e state_r;
    logic is_zero;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] table_high_r;
    logic [DATA_W-1:0] flags_r;
    logic [ADDR_W-1:0] dest_r;
    logic [DATA_W-1:0] wdata_r;
    logic we_r;
    logic take_skip;
    logic in_exec;
    logic start_table;
    logic load_acc;
    logic [PADDR_W-1:0] paddr_r;

    skip_test_unit u_test (
        .data_i(mem_rdata_i),
        .bit_sel_i(bit_sel_i),
        .bit_mode_i(op_i == OP_SKIP_BIT_ZERO),
        .is_zero_o(is_zero)
    );

    assign in_exec = instr_valid_i && (state_r == ST_EXEC);
    assign take_skip = in_exec && is_zero && is_skip_op(op_i);
    assign start_table = in_exec && is_table_op(op_i);
    assign load_acc = in_exec && (op_i == OP_SKIP_ZERO_LOAD_ACC);

    // sequencing: exec, then fetch of next, then dummy slot when skipping
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_r <= ST_EXEC;
        end else begin
            case (state_r)
                ST_EXEC: begin
                    if (take_skip) begin
                        state_r <= ST_SKIP_FETCH;
                    end else if (start_table) begin
                        state_r <= ST_TABLE;
                    end
                end
                ST_SKIP_FETCH: state_r <= ST_DUMMY;
                ST_DUMMY: state_r <= ST_EXEC;
                ST_TABLE: begin
                    if (prog_rvalid_i) begin
                        state_r <= ST_EXEC;
                    end
                end
                default: state_r <= ST_EXEC;
            endcase
        end
    end

    // accumulator load
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            acc_r <= ACC_RESET;
        end else if (load_acc) begin
            acc_r <= mem_rdata_i;
        end
    end

    // table read: latch destination, then split the fetched word
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dest_r <= '0;
            table_high_r <= TABLE_HIGH_RESET;
            wdata_r <= '0;
            we_r <= 1'b0;
        end else begin
            we_r <= 1'b0;
            if (start_table) begin
                dest_r <= mem_addr_i;
            end
            if (state_r == ST_TABLE && prog_rvalid_i) begin
                wdata_r <= prog_rdata_i[LOW_BYTE_LSB +: DATA_W];
                table_high_r <= prog_rdata_i[HIGH_BYTE_LSB +: DATA_W];
                we_r <= 1'b1;
            end
        end
    end

    // flags pass through untouched by these instructions
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_i;
        end
    end

    // program address held for the whole wait so the pointers may move on
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            paddr_r <= '0;
        end else if (start_table) begin
            paddr_r <= {table_ptr_high_i, table_ptr_low_i};
        end
    end

    assign prog_addr_o = paddr_r;
    assign prog_req_o = (state_r == ST_TABLE);
    assign busy_o = (state_r != ST_EXEC);
    assign dummy_cycle_o = (state_r == ST_SKIP_FETCH) || (state_r == ST_DUMMY);
    assign exec_enable_o = !dummy_cycle_o;
    assign acc_o = acc_r;
    assign table_high_latch_o = table_high_r;
    assign mem_we_o = we_r;
    assign mem_waddr_o = dest_r;
    assign mem_wdata_o = wdata_r;
    assign flags_o = flags_r;

    sequence skip_seq;
        state_r == ST_SKIP_FETCH ##1 state_r == ST_DUMMY ##1 state_r == ST_EXEC;
    endsequence

    skip_three_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        take_skip |=> skip_seq)
        else $error("taken skip did not last three cycles");
    skip_bit_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        in_exec && op_i == OP_SKIP_BIT_ZERO && !mem_rdata_i[bit_sel_i] |=> dummy_cycle_o[*2])
        else $error("bit skip missed its dummy cycle");
    skip_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        in_exec && op_i == OP_SKIP_ZERO_LOAD_ACC && mem_rdata_i == ZERO_BYTE |=> dummy_cycle_o)
        else $error("zero byte did not skip");
    no_skip_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        in_exec && op_i == OP_SKIP_ZERO_LOAD_ACC && mem_rdata_i != ZERO_BYTE |=> !dummy_cycle_o)
        else $error("nonzero value inserted a dummy cycle");
    acc_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        in_exec && op_i == OP_SKIP_ZERO_LOAD_ACC |=> acc_o == $past(mem_rdata_i))
        else $error("accumulator not loaded");
    table_low_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_r == ST_TABLE && prog_rvalid_i
            |=> mem_we_o && mem_wdata_o == $past(prog_rdata_i[LOW_BYTE_LSB +: DATA_W]))
        else $error("table low byte not written");
    table_high_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_r == ST_TABLE && prog_rvalid_i
            |=> table_high_latch_o == $past(prog_rdata_i[HIGH_BYTE_LSB +: DATA_W]))
        else $error("table high byte not latched");
    flags_kept_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        ##1 flags_o == $past(flags_i))
        else $error("flags altered");
    dummy_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        dummy_cycle_o |-> (!exec_enable_o && !mem_we_o)
            ##1 ($stable(acc_o) && $stable(table_high_latch_o)))
        else $error("dummy cycle had side effects");

    // table read: the start, then a request that waits for the word
    sequence table_start_seq;
        start_table;
    endsequence

    table_req_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        table_start_seq |=> prog_req_o
            && prog_addr_o == $past({table_ptr_high_i, table_ptr_low_i}))
        else $error("table read did not request the pointer address");
    table_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        prog_req_o && !prog_rvalid_i |=> prog_req_o && $stable(prog_addr_o))
        else $error("table request dropped before the word came");
    we_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        mem_we_o |=> !mem_we_o)
        else $error("data memory write lasted more than one cycle");
    busy_refuse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        busy_o |=> $stable(acc_o) && $stable(mem_waddr_o))
        else $error("request taken while busy");
    bit_no_skip_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        in_exec && op_i == OP_SKIP_BIT_ZERO && mem_rdata_i[bit_sel_i] |=> !dummy_cycle_o)
        else $error("set bit inserted a dummy cycle");
endmodule
`default_nettype wire

// *** logic/skip_exec_pkg.sv ***
// package: opcodes, widths and cycle figures for the skip and table-read executor
// assumes the core decodes instructions into one of the op codes below
`default_nettype none
package skip_exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PADDR_W = 16;
    localparam int PWORD_W = 16;
    localparam int BIT_SEL_W = 3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TABLE_HIGH_RESET = 8'h00;
    localparam int SKIP_CYCLES = 3;
    localparam int LOW_BYTE_LSB = 0;
    localparam int HIGH_BYTE_LSB = 8;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_SKIP_ZERO_LOAD_ACC,
        OP_SKIP_BIT_ZERO,
        OP_TABLE_READ_PAGE
    } op_e;
endpackage
`default_nettype wire

// *** logic/skip_test_unit.sv ***
// file: zero test used by both skip instructions
// assumes the byte is already read from data memory
`default_nettype none
module skip_test_unit (
    input wire logic [skip_exec_pkg::DATA_W-1:0] data_i,
    input wire logic [skip_exec_pkg::BIT_SEL_W-1:0] bit_sel_i,
    input wire logic bit_mode_i,
    output logic is_zero_o
);
    import skip_exec_pkg::*;
    always_comb begin
        if (bit_mode_i) begin
            is_zero_o = ~data_i[bit_sel_i];
        end else begin
            is_zero_o = (data_i == ZERO_BYTE);
        end
    end
endmodule
`default_nettype wire

// *** tb/prog_mem_model.sv ***
// program memory model answering table reads after a chosen latency
// assumes the request and address stay put until the word is handed over
`default_nettype none
module prog_mem_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic prog_req_i,
    input wire logic [15:0] addr_i,
    input wire logic [3:0] lat_i,
    output logic rvalid_o,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic [15:0] junk_r;
    // idle data keeps changing so stale words cannot pass
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            junk_r <= 16'hA55A;
        end else begin
            junk_r <= {junk_r[14:0], ~junk_r[15]};
        end
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i || !prog_req_i || rvalid_o) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    assign rvalid_o = prog_req_i && (cnt_r == lat_i);
    assign rdata_o = rvalid_o ? {addr_i[7:0] ^ 8'h3C, addr_i[15:8] ^ 8'h96} : junk_r;
endmodule
`default_nettype wire

// *** tb/tb_skip_and_table_read_exec.sv ***
// self-checking bench for the skip and table-read executor
// assumes the program memory model answers table reads
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error %0t: mismatch", $time); end end
module tb_skip_and_table_read_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import skip_exec_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic valid = 1'b0;
    op_e op = OP_NONE;
    logic [7:0] addr = 8'h00, rd = 8'h00, ph = 8'h00, pl = 8'h00, fl = 8'h00;
    logic [2:0] sel = 3'h0;
    logic [3:0] lat = 4'h0;
    logic prv, dummy, preq, we, busy, xen;
    logic [15:0] pword, paddr;
    logic [7:0] acc, thigh, waddr, wdata, flo;
    int error_cnt = 0;
    int total_checks = 0;
    always #20 mclk_i = ~mclk_i;
    skip_and_table_read_exec u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .instr_valid_i(valid),
        .op_i(op), .mem_addr_i(addr), .bit_sel_i(sel), .mem_rdata_i(rd),
        .table_ptr_high_i(ph), .table_ptr_low_i(pl), .prog_rdata_i(pword),
        .prog_rvalid_i(prv), .flags_i(fl), .busy_o(busy), .exec_enable_o(xen),
        .dummy_cycle_o(dummy), .acc_o(acc), .table_high_latch_o(thigh), .prog_addr_o(paddr),
        .prog_req_o(preq), .mem_we_o(we), .mem_waddr_o(waddr), .mem_wdata_o(wdata),
        .flags_o(flo));
    prog_mem_model u_pmem (.mclk_i(mclk_i), .reset_i(reset_i), .prog_req_i(preq),
        .addr_i(paddr), .lat_i(lat), .rvalid_o(prv), .rdata_o(pword));
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a second request rides along during a taken skip and must be ignored
    task automatic skip_run(op_e o, logic [7:0] b, logic [2:0] s, logic sk, logic [7:0] ea);
        int n;
        int nb;
        int nx;
        n = 0;
        nb = 0;
        nx = 0;
        @(posedge mclk_i);
        valid <= 1'b1;
        op <= o;
        rd <= b;
        sel <= s;
        fl <= b ^ 8'hC3;
        @(posedge mclk_i);
        valid <= sk;
        op <= OP_SKIP_ZERO_LOAD_ACC;
        rd <= 8'h5A;
        #1;
        `CHK(acc, ea)
        repeat (4) begin
            if (dummy === 1'b1) n++;
            if (busy === 1'b1) nb++;
            if (xen === 1'b0) nx++;
            @(posedge mclk_i);
            valid <= 1'b0;
            #1;
        end
        `CHK(n, sk ? SKIP_CYCLES - 1 : 0)
        `CHK(nb, sk ? SKIP_CYCLES - 1 : 0)
        `CHK(nx, sk ? SKIP_CYCLES - 1 : 0)
        `CHK(acc, ea)
        `CHK(flo, b ^ 8'hC3)
    endtask
    // pointers and destination move on after the start; the captured ones must be used
    task automatic table_run(logic [7:0] h, logic [7:0] l, logic [7:0] a, logic [3:0] t);
        int n;
        logic [15:0] pa;
        n = 0;
        pa = {h, l};
        @(posedge mclk_i);
        valid <= 1'b1;
        op <= OP_TABLE_READ_PAGE;
        addr <= a;
        ph <= h;
        pl <= l;
        lat <= t;
        fl <= h;
        @(posedge mclk_i);
        valid <= 1'b0;
        addr <= ~a;
        ph <= ~h;
        pl <= ~l;
        #1;
        `CHK(preq, 1'b1)
        `CHK(paddr, pa)
        while (we !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        `CHK(n, t + 1)
        `CHK(waddr, a)
        `CHK(wdata, h ^ 8'h96)
        `CHK(thigh, l ^ 8'h3C)
        `CHK(flo, h)
        @(posedge mclk_i);
        #1;
        `CHK(we, 1'b0)
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        skip_run(OP_SKIP_ZERO_LOAD_ACC, 8'h00, 3'h0, 1'b1, 8'h00);
        skip_run(OP_SKIP_ZERO_LOAD_ACC, 8'h01, 3'h0, 1'b0, 8'h01);
        skip_run(OP_SKIP_ZERO_LOAD_ACC, 8'h80, 3'h0, 1'b0, 8'h80);
        skip_run(OP_SKIP_BIT_ZERO, 8'hFE, 3'h0, 1'b1, 8'h80);
        skip_run(OP_SKIP_BIT_ZERO, 8'h80, 3'h7, 1'b0, 8'h80);
        skip_run(OP_SKIP_BIT_ZERO, 8'hF7, 3'h3, 1'b1, 8'h80);
        table_run(8'h12, 8'h34, 8'h40, 4'h0);
        table_run(8'hA7, 8'h0F, 8'h41, 4'h5);
        skip_run(OP_SKIP_ZERO_LOAD_ACC, 8'h00, 3'h0, 1'b1, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
